// ==== design/diag_counter_regs.sv ====
// diagnostic status, transfer counter, bus reset and vector registers
//
// How it works
// RULE1 - done bit set only after clean self-test
// RULE2 - reset command clears diagnostic command field
// RULE3 - clean reset reads 10000000 in diag_result
// RULE4 - diagnostic command touches only bits 6..3
// RULE5 - self-test fault loads code, then halts
// RULE6 - diag command runs, stores status, completes
// RULE7 - self-test codes 000 through 110 as listed
// RULE8 - nonzero command bits 6,4,2,1,0 give 100
// RULE9 - turnaround bytes and parity flag, else 110
// RULE10 - diag field codes 001 to 100 listed
// RULE11 - 24-bit counter, bytes high, mid, low
// RULE12 - counted mode limits bytes before interrupt
// RULE13 - single-byte mode leaves counter alone
// RULE14 - host loads counter before issuing command
// RULE15 - zero flag reads one when counter zero
// RULE16 - select unit 1024 clocks, abort on expiry
// RULE17 - zero count disables the selection timeout
// RULE18 - any write asserts SCSI bus reset
// RULE19 - any write releases SCSI bus reset
// RULE20 - vector 0 on second, vector 1 third
// RULE21 - vector on low byte with acknowledge
// RULE22 - first of three strobes is ignored
// RULE23 - answer only on matching interrupt level
// RULE24 - decrement per byte or per interval
`timescale 1ns/100ps
module diag_counter_regs (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire adapter_pkg::host_req_t host_req_in,
  input wire logic reset_cmd_in,
  input wire logic diag_cmd_in,
  input wire logic diag_bad_par_in,
  input wire logic [7:0] command_reg_in,
  input wire adapter_pkg::xfer_cmd_t xfer_cmd_in,
  input wire logic byte_moved_in,
  input wire logic bsy_in,
  input wire logic inta_in,
  input wire logic inta_cycle_in,
  input wire logic [2:0] int_id_in,
  input wire logic [2:0] int_level_in,
  input wire logic [7:0] vector1_in,
  output logic [7:0] rdata_out,
  output logic ack_out,
  output logic bus_rst_out,
  output logic halted_out,
  output logic fnc_done_out,
  output logic count_zero_flag_out,
  output logic xfer_limit_out,
  output logic sel_abort_out
);
  typedef enum logic [3:0] {
    S_BRANCH, S_FULL, S_INIT, S_CMD, S_DFLAG, S_TURN, S_PAR, S_DONE, S_HALT
  } test_state_t;

  test_state_t state_r, state_nxt;
  logic [7:0] diag_r, diag_nxt;
  logic [7:0] vec0_r;
  logic [7:0] loop_r;
  logic full_flag_r, dflag_r, par_flag_r;
  logic bus_rst_r;
  logic [1:0] strobe_cnt_r;
  logic [9:0] tick_cnt_r;
  logic tick;
  logic sel_wait_r, counting_r;
  logic [23:0] count_val;
  logic count_zero;
  logic [2:0] load;
  logic dec;
  logic wr_hit_high, wr_hit_mid, wr_hit_low;
  logic inta_match, give_vec0, give_vec1;
  logic [7:0] reg_rdata;
  logic fail;
  logic [2:0] fail_code;
  logic diag_go;
  logic [2:0] diag_code;

  function automatic logic hit(input adapter_pkg::host_req_t r,
                               input logic [5:0] off);
    return r.wr && r.addr == off;
  endfunction

  // register decode
  assign wr_hit_high = hit(host_req_in, adapter_pkg::OFF_CNT_HIGH);
  assign wr_hit_mid = hit(host_req_in, adapter_pkg::OFF_CNT_MID);
  assign wr_hit_low = hit(host_req_in, adapter_pkg::OFF_CNT_LOW);
  assign load = {wr_hit_high, wr_hit_mid, wr_hit_low}; // RULE11

  always_comb begin
    reg_rdata = 8'h00;
    unique case (host_req_in.addr)
      adapter_pkg::OFF_CNT_HIGH: reg_rdata = count_val[23:16]; // RULE11
      adapter_pkg::OFF_CNT_MID: reg_rdata = count_val[15:8];
      adapter_pkg::OFF_CNT_LOW: reg_rdata = count_val[7:0];
      adapter_pkg::OFF_DIAG: reg_rdata = diag_r;
      default: reg_rdata = 8'h00;
    endcase
  end

  // interrupt acknowledge decode
  assign inta_match = inta_in && inta_cycle_in &&
    int_id_in == int_level_in; // RULE23
  assign give_vec0 = inta_match &&
    strobe_cnt_r == adapter_pkg::STROBE_VEC0; // RULE20 RULE22
  assign give_vec1 = inta_match &&
    strobe_cnt_r == adapter_pkg::STROBE_VEC1; // RULE20

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strobe_cnt_r <= '0;
    end else if (!inta_cycle_in) begin
      strobe_cnt_r <= '0;
    end else if (inta_in && strobe_cnt_r != adapter_pkg::STROBE_VEC1) begin
      strobe_cnt_r <= strobe_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
      ack_out <= 1'b0;
    end else begin
      ack_out <= host_req_in.rd || host_req_in.wr ||
        give_vec0 || give_vec1; // RULE21
      rdata_out <= give_vec0 ? vec0_r :
        give_vec1 ? vector1_in :
        host_req_in.rd ? reg_rdata : 8'h00; // RULE21
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vec0_r <= adapter_pkg::VEC_RESET;
    end else if (hit(host_req_in, adapter_pkg::OFF_VEC0)) begin
      vec0_r <= host_req_in.wdata;
    end
  end

  // scsi bus reset drive; a release write in the same cycle wins
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_rst_r <= 1'b0;
    end else if (hit(host_req_in, adapter_pkg::OFF_RST_RELEASE)) begin
      bus_rst_r <= 1'b0; // RULE19
    end else if (hit(host_req_in, adapter_pkg::OFF_RST_ASSERT)) begin
      bus_rst_r <= 1'b1; // RULE18
    end
  end
  assign bus_rst_out = bus_rst_r;

  // 1024-clock interval divider, runs only while a select waits
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt_r <= '0;
    end else if (!sel_wait_r || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
    end
  end
  assign tick = sel_wait_r && tick_cnt_r == adapter_pkg::TICK_LAST; // RULE16

  // RULE24 RULE13: single-byte commands never count
  assign dec = (counting_r && byte_moved_in) || (sel_wait_r && tick);

  xfer_counter u_count (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .load_in(load),
    .wdata_in(host_req_in.wdata),
    .dec_in(dec),
    .value_out(count_val),
    .zero_out(count_zero)
  );

  // command tracking for counted transfers and select timeouts
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_wait_r <= 1'b0;
      counting_r <= 1'b0;
      sel_abort_out <= 1'b0;
      xfer_limit_out <= 1'b0;
      count_zero_flag_out <= 1'b1;
    end else begin
      count_zero_flag_out <= count_zero; // RULE15
      sel_abort_out <= 1'b0;
      xfer_limit_out <= 1'b0;
      if (state_r != S_DONE) begin
        sel_wait_r <= 1'b0;
        counting_r <= 1'b0;
      end else if (xfer_cmd_in.start) begin
        // RULE17: zero count means wait forever
        sel_wait_r <= xfer_cmd_in.is_select && !count_zero; // RULE16
        counting_r <= !xfer_cmd_in.is_select &&
          !xfer_cmd_in.single_byte; // RULE12 RULE13
      end else if (sel_wait_r && bsy_in) begin
        sel_wait_r <= 1'b0;
      end else if (sel_wait_r && tick &&
                   count_val == 24'h00_0001) begin
        sel_wait_r <= 1'b0;
        sel_abort_out <= 1'b1; // RULE16
      end else if (counting_r && byte_moved_in &&
                   count_val == 24'h00_0001) begin
        counting_r <= 1'b0;
        xfer_limit_out <= 1'b1; // RULE12
      end
    end
  end

  // self-test sequencer
  always_comb begin
    fail = 1'b0;
    fail_code = adapter_pkg::ST_PASS;
    state_nxt = state_r;
    unique case (state_r)
      S_BRANCH: state_nxt = S_FULL;
      S_FULL: begin
        fail = !full_flag_r;
        fail_code = adapter_pkg::ST_FULL; // RULE7
        state_nxt = S_INIT;
      end
      S_INIT: begin
        fail = bus_rst_r || dflag_r;
        fail_code = adapter_pkg::ST_INIT;
        state_nxt = S_CMD;
      end
      S_CMD: begin
        fail = |(command_reg_in & adapter_pkg::CMD_ZERO_MASK);
        fail_code = adapter_pkg::ST_CMDBITS; // RULE8
        state_nxt = S_DFLAG;
      end
      S_DFLAG: begin
        fail = !dflag_r;
        fail_code = adapter_pkg::ST_DFLAG;
        state_nxt = S_TURN;
      end
      S_TURN: begin
        fail = loop_r != adapter_pkg::PAT_A || !par_flag_r;
        fail_code = adapter_pkg::ST_TURN; // RULE9
        state_nxt = S_PAR;
      end
      S_PAR: begin
        fail = loop_r != adapter_pkg::PAT_B || par_flag_r;
        fail_code = adapter_pkg::ST_TURN; // RULE9
        state_nxt = S_DONE;
      end
      S_DONE: state_nxt = S_DONE;
      S_HALT: state_nxt = S_HALT; // RULE5
    endcase
    if (fail) begin
      state_nxt = S_HALT; // RULE5
    end
    if (reset_cmd_in) begin
      state_nxt = S_BRANCH;
    end
  end

  // diagnostic command: turnaround through the loop register
  assign diag_go = diag_cmd_in && state_r == S_DONE;
  assign diag_code = loop_r != adapter_pkg::PAT_B ?
    adapter_pkg::DC_MISS_FINAL :
    diag_bad_par_in ? adapter_pkg::DC_BAD_PAR :
    adapter_pkg::DC_GOOD_PAR; // RULE10

  always_comb begin
    diag_nxt = diag_r;
    if (reset_cmd_in) begin
      diag_nxt = adapter_pkg::DIAG_RESET_VAL; // RULE2
    end else if (fail) begin
      diag_nxt[2:0] = fail_code; // RULE5 RULE7
    end else if (state_r == S_PAR) begin
      diag_nxt[adapter_pkg::DONE_BIT] = 1'b1; // RULE1 RULE3
      diag_nxt[2:0] = adapter_pkg::ST_PASS;
    end else if (diag_go) begin
      // RULE4 RULE6: only the status field changes
      diag_nxt[adapter_pkg::DSTAT_MSB:adapter_pkg::DSTAT_LSB] =
        {1'b0, diag_code};
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= S_BRANCH;
      diag_r <= adapter_pkg::DIAG_RESET_VAL;
      fnc_done_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      diag_r <= diag_nxt;
      fnc_done_out <= diag_go && !reset_cmd_in; // RULE6
    end
  end

  // internal test flags and the turnaround path
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      full_flag_r <= 1'b0;
      dflag_r <= 1'b0;
      par_flag_r <= 1'b0;
      loop_r <= 8'h00;
    end else begin
      full_flag_r <= state_nxt == S_FULL;
      dflag_r <= state_nxt == S_DFLAG;
      par_flag_r <= state_nxt == S_TURN;
      loop_r <= (state_nxt == S_TURN) ? adapter_pkg::PAT_A :
        adapter_pkg::PAT_B; // RULE9
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      halted_out <= 1'b0;
    end else begin
      halted_out <= state_nxt == S_HALT; // RULE5
    end
  end

  // checks
  pass_pattern_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    state_r == S_PAR && !reset_cmd_in && !fail
    |=> diag_r == adapter_pkg::DIAG_PASS_VAL || diag_r[6:3] != 4'h0)
    else $error("clean self-test did not give pass pattern"); // RULE3
  done_only_pass_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(diag_r[adapter_pkg::DONE_BIT]) |-> diag_r[2:0] == 3'h0)
    else $error("done bit set with failure code"); // RULE1
  reset_clear_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    reset_cmd_in |=> diag_r[6:3] == 4'h0)
    else $error("reset command left diag field"); // RULE2
  diag_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    diag_go && !reset_cmd_in |=> diag_r[7] == $past(diag_r[7]) &&
      diag_r[2:0] == $past(diag_r[2:0]))
    else $error("diag command altered test bits"); // RULE4
  diag_done_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    diag_go && !reset_cmd_in |=> fnc_done_out && diag_r[5:3] != 3'h0)
    else $error("diag command gave no completion"); // RULE6
  halt_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    state_r == S_HALT && !reset_cmd_in |=> state_r == S_HALT)
    else $error("halt left without reset"); // RULE5
  cmd_bits_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    state_r == S_CMD && !reset_cmd_in &&
    (command_reg_in & adapter_pkg::CMD_ZERO_MASK) != 8'h00
    |=> diag_r[2:0] == adapter_pkg::ST_CMDBITS && halted_out)
    else $error("command bit fault not reported"); // RULE8
  single_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !counting_r && !sel_wait_r && load == 3'h0 |=> $stable(count_val))
    else $error("counter moved outside a counted command"); // RULE13
  zero_flag_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    1'b1 |=> count_zero_flag_out == ($past(count_val) == 24'h00_0000))
    else $error("zero flag wrong"); // RULE15
  no_abort_zero_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    state_r == S_DONE && xfer_cmd_in.start && xfer_cmd_in.is_select &&
    count_zero |=> !sel_wait_r ##1 !sel_abort_out)
    else $error("zero count started a timeout"); // RULE17
  bus_rst_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    host_req_in.wr && host_req_in.addr == adapter_pkg::OFF_RST_ASSERT
    |=> bus_rst_out)
    else $error("bus reset not asserted"); // RULE18
  bus_rst_rel_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    host_req_in.wr && host_req_in.addr == adapter_pkg::OFF_RST_RELEASE
    |=> !bus_rst_out)
    else $error("bus reset not released"); // RULE19
  vec0_give_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    give_vec0 |=> ack_out && rdata_out == $past(vec0_r))
    else $error("vector 0 not returned"); // RULE20
  inta_first_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    inta_in && strobe_cnt_r == 2'h0 && !host_req_in.rd &&
    !host_req_in.wr |=> !ack_out)
    else $error("first strobe answered"); // RULE22
endmodule

// ==== design/adapter_pkg.sv ====
// shared constants and types for the diagnostic and counter register group
package adapter_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CNT_HIGH = 6'h1c;
  localparam logic [5:0] OFF_CNT_MID = 6'h1d;
  localparam logic [5:0] OFF_CNT_LOW = 6'h1e;
  localparam logic [5:0] OFF_DIAG = 6'h19;
  localparam logic [5:0] OFF_RST_ASSERT = 6'h20;
  localparam logic [5:0] OFF_VEC0 = 6'h21;
  localparam logic [5:0] OFF_RST_RELEASE = 6'h27;
  localparam int DONE_BIT = 7;
  localparam int DSTAT_LSB = 3;
  localparam int DSTAT_MSB = 6;
  localparam logic [7:0] CMD_ZERO_MASK = 8'h57;
  localparam logic [7:0] DIAG_RESET_VAL = 8'h00;
  localparam logic [7:0] DIAG_PASS_VAL = 8'h80;
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] PAT_A = 8'h55;
  localparam logic [7:0] PAT_B = 8'haa;
  localparam int CLK_MHZ = 100;
  localparam int TICK_PERIODS = 1024;
  localparam int TICK_CYCLES = TICK_PERIODS;
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);
  // self-test codes
  localparam logic [2:0] ST_PASS = 3'h0;
  localparam logic [2:0] ST_BRANCH = 3'h1;
  localparam logic [2:0] ST_FULL = 3'h2;
  localparam logic [2:0] ST_INIT = 3'h3;
  localparam logic [2:0] ST_CMDBITS = 3'h4;
  localparam logic [2:0] ST_DFLAG = 3'h5;
  localparam logic [2:0] ST_TURN = 3'h6;
  // diagnostic command codes
  localparam logic [2:0] DC_NONE = 3'h0;
  localparam logic [2:0] DC_MISS_INIT = 3'h1;
  localparam logic [2:0] DC_MISS_FINAL = 3'h2;
  localparam logic [2:0] DC_GOOD_PAR = 3'h3;
  localparam logic [2:0] DC_BAD_PAR = 3'h4;
  localparam logic [1:0] STROBE_VEC0 = 2'h1;
  localparam logic [1:0] STROBE_VEC1 = 2'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic start;
    logic is_select;
    logic single_byte;
  } xfer_cmd_t;
endpackage

// ==== design/xfer_counter.sv ====
// 24-bit transfer counter built from three loadable byte counters
`timescale 1ns/100ps
module xfer_counter (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [2:0] load_in,
  input wire logic [7:0] wdata_in,
  input wire logic dec_in,
  output logic [23:0] value_out,
  output logic zero_out
);
  logic [23:0] count_r;
  logic [23:0] count_nxt;
  logic [23:0] dec_val;

  assign dec_val = count_r - 24'h00_0001;

  // byte 2 is most significant, byte 0 least; a load wins over a decrement
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_byte
      assign count_nxt[g*8 +: 8] = load_in[g] ? wdata_in :
        (dec_in && count_r != '0) ? dec_val[g*8 +: 8] : count_r[g*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign value_out = count_r;
  assign zero_out = (count_r == '0);
endmodule

// ==== bench/host_model.sv ====
// host cpu model: register accesses and interrupt acknowledge strobes
`timescale 1ns/100ps
module host_model (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  input wire logic ack_in,
  output adapter_pkg::host_req_t host_req_out,
  output logic inta_out,
  output logic inta_cycle_out,
  output logic [2:0] int_id_out
);
  initial begin
    host_req_out = '0;
    inta_out = 1'b0;
    inta_cycle_out = 1'b0;
    int_id_out = 3'h0;
  end

  // one-cycle access; released address and data lines show the inverse pattern, wr and rd drop to 0
  task automatic access(input logic wr, input logic [5:0] addr,
      input logic [7:0] wdata, output logic ack, output logic [7:0] rdata);
    @(posedge clock_in);
    host_req_out <= {wr, ~wr, addr, wdata};
    @(posedge clock_in);
    host_req_out <= {1'b0, 1'b0, ~addr, ~wdata};
    @(posedge clock_in);
    ack = ack_in;
    rdata = rdata_in;
  endtask

  task automatic begin_ack(input logic [2:0] id);
    @(posedge clock_in);
    inta_cycle_out <= 1'b1;
    int_id_out <= id;
  endtask

  task automatic end_ack();
    @(posedge clock_in);
    inta_cycle_out <= 1'b0;
    int_id_out <= ~int_id_out;
  endtask

  // one strobe of a two- or three-strobe sequence
  task automatic strobe(output logic ack, output logic [7:0] rdata);
    @(posedge clock_in);
    inta_out <= 1'b1;
    @(posedge clock_in);
    inta_out <= 1'b0;
    @(posedge clock_in);
    ack = ack_in;
    rdata = rdata_in;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the diagnostic and counter register group
`timescale 1ns/100ps
module tb_top;
  logic clock_in = 1'b0, rstn_in = 1'b0, reset_cmd = 1'b0, diag_cmd = 1'b0;
  logic bad_par = 1'b0, byte_moved = 1'b0, bsy = 1'b0;
  logic ack, bus_rst, halted, fnc_done, cz_flag, xfer_limit, sel_abort;
  logic inta, inta_cycle, ack_s, ok;
  logic [7:0] command_reg = 8'h00, vector1 = 8'h00, rdata, rd_s, v0;
  logic [2:0] int_level = 3'h0, int_id;
  logic [31:0] seed = 32'h0000_62d7, r;
  adapter_pkg::host_req_t host_req;
  adapter_pkg::xfer_cmd_t xfer_cmd = '0;
  int n_mismatch = 0, num_checks = 0, cycles = 0, n_limit = 0, n_abort = 0;
  int abort_at = 0, t0 = 0, n;
  logic [7:0] fault_bits [5] = '{8'h40, 8'h10, 8'h04, 8'h02, 8'h01};

  diag_counter_regs i_diag_counter_regs (.clock_in(clock_in),
    .rstn_in(rstn_in), .host_req_in(host_req), .reset_cmd_in(reset_cmd),
    .diag_cmd_in(diag_cmd), .diag_bad_par_in(bad_par),
    .command_reg_in(command_reg), .xfer_cmd_in(xfer_cmd),
    .byte_moved_in(byte_moved), .bsy_in(bsy), .inta_in(inta),
    .inta_cycle_in(inta_cycle), .int_id_in(int_id),
    .int_level_in(int_level), .vector1_in(vector1), .rdata_out(rdata),
    .ack_out(ack), .bus_rst_out(bus_rst), .halted_out(halted),
    .fnc_done_out(fnc_done), .count_zero_flag_out(cz_flag),
    .xfer_limit_out(xfer_limit), .sel_abort_out(sel_abort));

  host_model i_host_model (.clock_in(clock_in), .rdata_in(rdata),
    .ack_in(ack), .host_req_out(host_req), .inta_out(inta),
    .inta_cycle_out(inta_cycle), .int_id_out(int_id));

  always #5 clock_in = ~clock_in;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (xfer_limit === 1'b1) n_limit <= n_limit + 1;
    if (sel_abort === 1'b1) begin
      n_abort <= n_abort + 1;
      abort_at <= cycles;
    end
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] diag_exp(input logic [7:0] c,
      input logic [2:0] d);
    if ((c & adapter_pkg::CMD_ZERO_MASK) != 8'h00)
      return {5'h00, adapter_pkg::ST_CMDBITS};
    return {2'b10, d, adapter_pkg::ST_PASS};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
      input string msg);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_host_model.access(1'b1, a, d, ack_s, rd_s);
    chk({7'h0, ack_s}, 8'h01, "write ack");
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    i_host_model.access(1'b0, a, 8'h00, ack_s, rd_s);
    chk({7'h0, ack_s}, 8'h01, "read ack");
    chk(rd_s, exp, "read data");
  endtask

  task automatic load(input logic [23:0] v);
    wr(adapter_pkg::OFF_CNT_HIGH, v[23:16]);
    wr(adapter_pkg::OFF_CNT_MID, v[15:8]);
    wr(adapter_pkg::OFF_CNT_LOW, v[7:0]);
  endtask

  task automatic readback(input logic [23:0] v);
    rd(adapter_pkg::OFF_CNT_HIGH, v[23:16]);
    rd(adapter_pkg::OFF_CNT_MID, v[15:8]);
    rd(adapter_pkg::OFF_CNT_LOW, v[7:0]);
  endtask

  task automatic reset_command();
    @(posedge clock_in);
    reset_cmd <= 1'b1;
    @(posedge clock_in);
    reset_cmd <= 1'b0;
    repeat (9) @(posedge clock_in);
  endtask

  task automatic diag(input logic bad);
    @(posedge clock_in);
    diag_cmd <= 1'b1;
    bad_par <= bad;
    @(posedge clock_in);
    diag_cmd <= 1'b0;
    @(posedge clock_in);
    chk({7'h0, fnc_done}, 8'h01, "function complete");
  endtask

  task automatic start(input logic sel, input logic single);
    @(posedge clock_in);
    xfer_cmd <= {1'b1, sel, single};
    @(posedge clock_in);
    xfer_cmd <= {1'b0, sel, single};
    t0 = cycles;
  endtask

  task automatic byte_pulse();
    @(posedge clock_in);
    byte_moved <= 1'b1;
    @(posedge clock_in);
    byte_moved <= 1'b0;
  endtask

  task automatic strb(input logic e, input logic [7:0] d);
    i_host_model.strobe(ack_s, rd_s);
    chk({7'h0, ack_s}, {7'h0, e}, "strobe ack");
    if (e) chk(rd_s, d, "vector byte");
  endtask

  initial begin
    repeat (5) @(posedge clock_in);
    chk({7'h0, cz_flag}, 8'h01, "zero flag in reset");
    chk({5'h00, bus_rst, halted, ack}, 8'h00, "outputs in reset");
    v0 = 8'(rnd());
    command_reg <= fault_bits[v0 % 5] | (v0 & 8'ha8);
    rstn_in <= 1'b1;
    repeat (9) @(posedge clock_in);
    rd(adapter_pkg::OFF_DIAG, diag_exp(command_reg, 3'h0));
    chk({7'h0, halted}, 8'h01, "halt after fault");
    command_reg <= v0 & 8'ha8;
    reset_command();
    chk({7'h0, halted}, 8'h00, "halt cleared");
    rd(adapter_pkg::OFF_DIAG, diag_exp(command_reg, 3'h0));
    wr(adapter_pkg::OFF_DIAG, v0);
    diag(1'b0);
    rd(adapter_pkg::OFF_DIAG, diag_exp(8'h00, 3'h3));
    diag(1'b1);
    rd(adapter_pkg::OFF_DIAG, diag_exp(8'h00, 3'h4));
    reset_command();
    rd(adapter_pkg::OFF_DIAG, diag_exp(8'h00, 3'h0));
    for (int i = 0; i < 4; i++) begin
      r = (i == 3) ? 32'h0 : rnd();
      load(r[23:0]);
      readback(r[23:0]);
      chk({7'h0, cz_flag}, {7'h0, r[23:0] == 24'h0}, "zero flag");
    end
    n = 2 + int'(rnd() % 4);
    load(24'(n));
    start(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      chk(8'(n_limit), 8'h00, "early limit");
      byte_pulse();
    end
    repeat (3) @(posedge clock_in);
    chk(8'(n_limit), 8'h01, "limit after count");
    readback(24'h0);
    r = rnd() | 32'h1;
    load(r[23:0]);
    start(1'b0, 1'b1);
    repeat (3) byte_pulse();
    readback(r[23:0]);
    chk(8'(n_limit), 8'h01, "limit in single byte");
    n = 2 + int'(rnd() % 2);
    load(24'(n));
    start(1'b1, 1'b0);
    for (int i = 0; i < 1024 * n + 8 && n_abort == 0; i++) @(posedge clock_in);
    chk(8'(n_abort), 8'h01, "select abort");
    ok = abort_at - t0 >= 1024 * (n - 1) && abort_at - t0 <= 1024 * n + 4;
    chk({7'h0, ok}, 8'h01, "abort time");
    load(24'h2);
    start(1'b1, 1'b0);
    repeat (100) @(posedge clock_in);
    bsy <= 1'b1;
    repeat (2200) @(posedge clock_in);
    bsy <= 1'b0;
    chk(8'(n_abort), 8'h01, "abort despite busy");
    load(24'h0);
    start(1'b1, 1'b0);
    repeat (2200) @(posedge clock_in);
    chk(8'(n_abort), 8'h01, "abort with zero count");
    wr(adapter_pkg::OFF_RST_ASSERT, 8'(rnd()));
    chk({7'h0, bus_rst}, 8'h01, "bus reset on");
    wr(adapter_pkg::OFF_RST_RELEASE, 8'(rnd()));
    chk({7'h0, bus_rst}, 8'h00, "bus reset off");
    rd(6'h3f, 8'h00);
    v0 = 8'(rnd());
    wr(adapter_pkg::OFF_VEC0, v0);
    vector1 <= 8'(rnd());
    int_level <= 3'(rnd());
    @(posedge clock_in);
    i_host_model.begin_ack(int_level);
    strb(1'b0, 8'h00);
    strb(1'b1, v0);
    strb(1'b1, vector1);
    i_host_model.end_ack();
    i_host_model.begin_ack(int_level ^ 3'h1);
    strb(1'b0, 8'h00);
    strb(1'b0, 8'h00);
    i_host_model.end_ack();
    i_host_model.begin_ack(int_level);
    strb(1'b0, 8'h00);
    strb(1'b1, v0);
    i_host_model.end_ack();
    // halt on a command bit fault, then leave it by the reset pin
    command_reg <= fault_bits[0];
    reset_command();
    chk({7'h0, halted}, 8'h01, "halt on command bit");
    command_reg <= 8'h00;
    @(posedge clock_in);
    rstn_in <= 1'b0;
    @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (9) @(posedge clock_in);
    chk({7'h0, halted}, 8'h00, "halt cleared by reset pin");
    rd(adapter_pkg::OFF_DIAG, diag_exp(8'h00, 3'h0));
    end_of_test();
  end
endmodule
